// [hw/nbc_consts.svh]
// constants for the nibble core datapath: offsets, fields, vectors, counts
//
// Overview of operation
// [RQ1] program counter is twelve bits: page bit 11 above an 11-bit wrapping counter
// [RQ2] jump instruction loads the page bit, reaching code above the 2K boundary
// [RQ3] fetch addresses stay inside a 4K word program space
// [RQ4] ALU does add, subtract, decimal adjust, logic ops, branch tests, shift right
// [RQ5] carry flag takes the carry or no-borrow of every arithmetic operation
// [RQ6] calls and interrupts push carry with return address; interrupt return restores it
// [RQ7] return with constant pops the address but keeps the current carry
// [RQ8] accumulator is four bits and exchanges data with memory and registers
// [RQ9] table jump goes to page bits 11..8, then table register, then accumulator
// [RQ10] return with constant loads word bits 7..4 to table register, 3..0 to accumulator
// [RQ11] data pointer is high and middle parts of three bits, low part of four
// [RQ12] the pseudo index location accesses memory at pointer high, middle, low
// [RQ13] indirect addresses reach up to 3FF hex
// [RQ14] stack holds eight 13-bit entries, carry on top of pc bits 11..0
// [RQ15] stack is last in first out; calls push, returns pop into the pc
// [RQ16] a ninth nested push drops the oldest entry
// [RQ17] one instruction takes four oscillator periods
// [RQ18] converter, two timers and falling port edges interrupt, each using one level
// [RQ19] reset pc is 000; vectors 001 converter, 002 timer0, 003 timer1, 004 port
// [RQ20] 192 nibbles of data ram at 030..0EF keep contents while idle
// [RQ21] decimal add adds six above nine or on carry; decimal sub subtracts six on borrow
`ifndef NBC_CONSTS_SVH
`define NBC_CONSTS_SVH

`define NBC_RESET_PC 12'h000
`define NBC_VEC_ADC 12'h001
`define NBC_VEC_TMR0 12'h002
`define NBC_VEC_TMR1 12'h003
`define NBC_VEC_PORT 12'h004
`define NBC_STACK_DEPTH 8
`define NBC_STACK_FULL 4'h8
`define NBC_INX_ADDR 10'h00F
`define NBC_RAM_LO 10'h030
`define NBC_RAM_HI 10'h0EF
`define NBC_RAM_WORDS 192
`define NBC_OSC_PER_INSN 4
`define NBC_BCD_MAX 4'h9
`define NBC_BCD_ADJ 5'h06
`define NBC_BCD_SUB 4'hA
`define NBC_REG_CMD 8'h00
`define NBC_REG_STATUS 8'h04
`define NBC_REG_DPTR 8'h08
`define NBC_REG_IRQ 8'h0C
`define NBC_REG_CORE 8'h10

`endif

// [hw/nbc_pkg.sv]
// types shared by the nibble core datapath and its return stack
package nbc_pkg;
`include "nbc_consts.svh"

  // one-hot instruction phases
  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_ADDR = 5'h02,
    PH_READ = 5'h04,
    PH_LATCH = 5'h08,
    PH_EXEC = 5'h10
  } nbc_phase_e;

  // operation codes accepted by the command register
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADC, OP_ADD, OP_SBC, OP_SUB, OP_ADI, OP_SBI,
    OP_DEC_ADD, OP_DEC_SUB, OP_AND, OP_EOR, OP_OR, OP_ANDIM, OP_EORIM,
    OP_ORIM, OP_BIT_BR, OP_ZERO_BR, OP_CARRY_BR, OP_SHIFT_R, OP_LOAD,
    OP_STORE, OP_LOAD_IMM, OP_JUMP, OP_CALL, OP_RET_INT, OP_RET_CONST,
    OP_TABLE_JUMP
  } nbc_op_e;

  typedef struct packed {
    nbc_op_e op;
    logic [3:0] imm;
    logic [11:0] addr;
  } nbc_cmd_s;

  typedef struct packed {
    logic cy;
    logic [3:0] acc;
    logic [3:0] mem;
    logic wr_mem;
  } nbc_alu_s;

  typedef struct packed {
    logic rd;
    logic we;
    logic [9:0] addr;
    logic [3:0] wdata;
  } nbc_dm_s;

  typedef struct packed {
    logic cy;
    logic [11:0] pc;
  } nbc_frame_s;

  typedef struct packed {
    nbc_frame_s [`NBC_STACK_DEPTH-1:0] ent;
    logic [3:0] depth;
    logic lost;
  } nbc_stack_s;
endpackage

// [hw/nbc_stack.sv]
// eight-level return stack holding carry and program counter
module nbc_stack import nbc_pkg::*; (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // push and pop requests
  input wire logic push_in,
  input wire logic pop_in,
  input wire nbc_frame_s push_frame_in,
  // state seen by the core
  output nbc_frame_s top_out,
  output logic [3:0] depth_out,
  output logic lost_out
);
  nbc_stack_s s_q, s_d;

  // shift-register stack, entry 0 is the top
  always_comb begin
    s_d = s_q;
    if (push_in) begin
      for (int i = `NBC_STACK_DEPTH - 1; i > 0; i--) begin
        s_d.ent[i] = s_q.ent[i-1]; // bottom falls off when full [RQ16]
      end
      s_d.ent[0] = push_frame_in; // carry above pc [RQ14] [RQ15]
      if (s_q.depth == `NBC_STACK_FULL) begin
        s_d.lost = 1'b1; // [RQ16]
      end else begin
        s_d.depth = s_q.depth + 4'h1;
      end
    end else if (pop_in) begin
      for (int i = 0; i < `NBC_STACK_DEPTH - 1; i++) begin
        s_d.ent[i] = s_q.ent[i+1]; // last in first out [RQ15]
      end
      s_d.ent[`NBC_STACK_DEPTH-1] = '0;
      if (s_q.depth != 4'h0) begin
        s_d.depth = s_q.depth - 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign top_out = s_q.ent[0];
  assign depth_out = s_q.depth;
  assign lost_out = s_q.lost;
endmodule

// [hw/nbc_core.sv]
// nibble core datapath: pc, alu, accumulator, pointer, ram and wishbone slave
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
module nbc_core import nbc_pkg::*; (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // interrupt sources
  input wire logic adc_irq_in,
  input wire logic tmr0_irq_in,
  input wire logic tmr1_irq_in,
  input wire logic [1:0] port_grp_in,
  // program rom fetch address
  output logic [11:0] rom_addr_out,
  // system register and external data port
  output nbc_dm_s dm_out,
  input wire logic [3:0] dm_rdata_in
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------

  typedef struct packed {
    nbc_phase_e phase;
    nbc_cmd_s cmd;
    logic [11:0] pc;
    logic [3:0] acc;
    logic [3:0] table_branch_register;
    logic cy;
    logic [3:0] pointer_low_part;
    logic [2:0] pointer_middle_part;
    logic [2:0] pointer_high_part;
    logic [3:0] mdata;
    logic internal;
    logic [3:0] irq_en;
    logic [3:0] pend;
    logic [1:0] port_prev;
    logic ack;
    logic [31:0] rdata;
    nbc_dm_s dm;
  } nbc_core_s;

  nbc_core_s s_q, s_d;
  logic [3:0] ram_q [`NBC_RAM_WORDS]; // data ram, never reset [RQ20]
  nbc_alu_s alu_r;
  nbc_frame_s top_w;
  nbc_frame_s push_frame;
  logic [3:0] depth_w;
  logic lost_w;
  logic push_w;
  logic pop_w;
  logic wb_wr;
  logic start_w;
  logic [3:0] take_w;
  logic [3:0] events_w;
  logic [9:0] eff_w;
  logic [7:0] ram_idx;
  logic [11:0] pc_inc;
  logic [31:0] rd_word;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------

  // byte-lane merge of a wishbone write
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // operations that read a data nibble
  function automatic logic reads_mem(input nbc_op_e op);
    case (op)
      OP_ADC, OP_ADD, OP_SBC, OP_SUB, OP_ADI, OP_SBI, OP_AND, OP_EOR,
      OP_OR, OP_ANDIM, OP_EORIM, OP_ORIM, OP_LOAD: reads_mem = 1'b1;
      default: reads_mem = 1'b0;
    endcase
  endfunction

  // fixed priority: converter, timer0, timer1, port
  function automatic logic [3:0] pick_irq(input logic [3:0] req);
    casez (req)
      4'b1???: pick_irq = 4'h8;
      4'b01??: pick_irq = 4'h4;
      4'b001?: pick_irq = 4'h2;
      4'b0001: pick_irq = 4'h1;
      default: pick_irq = 4'h0;
    endcase
  endfunction

  // entry address of an accepted interrupt
  function automatic logic [11:0] irq_vector(input logic [3:0] one);
    case (one)
      4'h8: irq_vector = `NBC_VEC_ADC; // [RQ19]
      4'h4: irq_vector = `NBC_VEC_TMR0;
      4'h2: irq_vector = `NBC_VEC_TMR1;
      default: irq_vector = `NBC_VEC_PORT;
    endcase
  endfunction

  // nibble alu; carry set means carry out or no borrow
  function automatic nbc_alu_s alu(input nbc_op_e op, input logic [3:0] a,
                                   input logic [3:0] m, input logic [3:0] imm,
                                   input logic cy);
    nbc_alu_s r;
    logic [4:0] sum;
    r.cy = cy;
    r.acc = a;
    r.mem = m;
    r.wr_mem = 1'b0;
    sum = 5'h00;
    case (op)
      OP_ADC: sum = {1'b0, m} + {1'b0, a} + {4'h0, cy};
      OP_ADD: sum = {1'b0, m} + {1'b0, a};
      OP_SBC: sum = {1'b0, m} + {1'b0, ~a} + {4'h0, cy};
      OP_SUB: sum = {1'b0, m} + {1'b0, ~a} + 5'h01;
      OP_ADI: sum = {1'b0, m} + {1'b0, imm};
      OP_SBI: sum = {1'b0, m} + {1'b0, ~imm} + 5'h01;
      default: sum = 5'h00;
    endcase
    case (op)
      OP_ADC, OP_ADD, OP_SBC, OP_SUB, OP_ADI, OP_SBI: begin
        r.acc = sum[3:0];
        r.cy = sum[4]; // [RQ5]
      end
      OP_DEC_ADD: begin
        if (a > `NBC_BCD_MAX || cy) begin
          sum = {1'b0, a} + `NBC_BCD_ADJ; // [RQ21]
          r.acc = sum[3:0];
          r.cy = 1'b1;
        end
      end
      OP_DEC_SUB: begin
        if (!cy) begin
          r.acc = a + `NBC_BCD_SUB; // minus six, borrow kept [RQ21]
        end
      end
      OP_AND: r.acc = a & m;
      OP_EOR: r.acc = a ^ m;
      OP_OR: r.acc = a | m;
      OP_ANDIM: begin
        r.mem = m & imm;
        r.wr_mem = 1'b1;
      end
      OP_EORIM: begin
        r.mem = m ^ imm;
        r.wr_mem = 1'b1;
      end
      OP_ORIM: begin
        r.mem = m | imm;
        r.wr_mem = 1'b1;
      end
      OP_SHIFT_R: begin
        r.acc = {1'b0, a[3:1]};
        r.cy = a[0];
      end
      OP_LOAD: r.acc = m; // [RQ8]
      OP_LOAD_IMM: r.acc = imm;
      OP_STORE: begin
        r.mem = a; // [RQ8]
        r.wr_mem = 1'b1;
      end
      default: r.cy = cy;
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------
  // datapath terms
  // --------------------------------------------------------------

  // pseudo index location redirects to the pointer [RQ12] [RQ13]
  assign eff_w = (s_q.cmd.addr[9:0] == `NBC_INX_ADDR) ?
                 {s_q.pointer_high_part, s_q.pointer_middle_part, s_q.pointer_low_part} : s_q.cmd.addr[9:0]; // [RQ11]
  assign ram_idx = 8'(s_q.dm.addr - `NBC_RAM_LO);
  assign pc_inc = {s_q.pc[11], s_q.pc[10:0] + 11'h001}; // page bit held [RQ1]
  assign alu_r = alu(s_q.cmd.op, s_q.acc, s_q.mdata, s_q.cmd.imm, s_q.cy); // [RQ4]
  assign wb_wr = wb_cyc_in && wb_stb_in && wb_we_in && s_q.ack;
  assign start_w = wb_wr && (wb_adr_in == `NBC_REG_CMD) && (s_q.phase == PH_IDLE);
  assign events_w = {adc_irq_in, tmr0_irq_in, tmr1_irq_in,
                     |(s_q.port_prev & ~port_grp_in)}; // falling edge [RQ18]
  assign take_w = (s_q.phase == PH_IDLE && !start_w) ?
                  pick_irq(s_q.pend & s_q.irq_en) : 4'h0;

  // stack control: calls and interrupts push, returns pop
  assign push_w = (|take_w) || (s_q.phase == PH_EXEC && s_q.cmd.op == OP_CALL); // [RQ18]
  assign pop_w = s_q.phase == PH_EXEC &&
                 (s_q.cmd.op == OP_RET_INT || s_q.cmd.op == OP_RET_CONST); // [RQ15]
  assign push_frame = '{cy: s_q.cy,
                        pc: (|take_w) ? s_q.pc : pc_inc}; // [RQ6]

  nbc_stack u_stack (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .push_in(push_w),
    .pop_in(pop_w),
    .push_frame_in(push_frame),
    .top_out(top_w),
    .depth_out(depth_w),
    .lost_out(lost_w)
  );

  // register read mux
  always_comb begin
    case (wb_adr_in)
      `NBC_REG_CMD: rd_word = {s_q.phase != PH_IDLE, 10'h000, s_q.cmd};
      `NBC_REG_STATUS: rd_word = {6'h00, lost_w, depth_w, s_q.cy, s_q.table_branch_register,
                                  s_q.acc, s_q.pc};
      `NBC_REG_DPTR: rd_word = {22'h000000, s_q.pointer_high_part, s_q.pointer_middle_part, s_q.pointer_low_part};
      `NBC_REG_IRQ: rd_word = {24'h000000, s_q.pend, s_q.irq_en};
      `NBC_REG_CORE: rd_word = {23'h000000, s_q.cy, s_q.table_branch_register, s_q.acc};
      default: rd_word = 32'h00000000;
    endcase
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------

  always_comb begin
    logic [31:0] w;
    w = 32'h00000000;
    s_d = s_q;
    s_d.dm.rd = 1'b0;
    s_d.dm.we = 1'b0;
    s_d.port_prev = port_grp_in;
    // pending: a new event wins over the clear on acceptance
    s_d.pend = (s_q.pend & ~take_w) | events_w;

    // wishbone: registered ack, write lands on the ack edge
    s_d.ack = wb_cyc_in && wb_stb_in && !s_q.ack;
    if (wb_cyc_in && wb_stb_in && !s_q.ack) begin
      s_d.rdata = rd_word;
    end
    if (wb_wr) begin
      case (wb_adr_in)
        `NBC_REG_DPTR: begin
          w = wb_merge({22'h000000, s_q.pointer_high_part, s_q.pointer_middle_part, s_q.pointer_low_part}, wb_dat_in, wb_sel_in);
          s_d.pointer_low_part = w[3:0]; // [RQ11]
          s_d.pointer_middle_part = w[6:4];
          s_d.pointer_high_part = w[9:7];
        end
        `NBC_REG_IRQ: begin
          w = wb_merge({28'h0000000, s_q.irq_en}, wb_dat_in, wb_sel_in);
          s_d.irq_en = w[3:0];
        end
        `NBC_REG_CORE: begin
          if (s_q.phase == PH_IDLE) begin
            w = wb_merge({23'h000000, s_q.cy, s_q.table_branch_register, s_q.acc}, wb_dat_in, wb_sel_in);
            s_d.acc = w[3:0];
            s_d.table_branch_register = w[7:4];
            s_d.cy = w[8];
          end
        end
        default: w = 32'h00000000;
      endcase
    end

    // four-phase instruction cycle [RQ17]
    case (s_q.phase)
      PH_IDLE: begin
        if (start_w) begin
          w = wb_merge({11'h000, s_q.cmd}, wb_dat_in, wb_sel_in);
          s_d.cmd = nbc_cmd_s'(w[20:0]);
          s_d.phase = PH_ADDR;
        end else if (|take_w) begin
          s_d.pc = irq_vector(take_w); // [RQ19]
        end
      end
      PH_ADDR: begin
        s_d.dm.addr = eff_w;
        s_d.internal = eff_w >= `NBC_RAM_LO && eff_w <= `NBC_RAM_HI;
        s_d.dm.rd = reads_mem(s_q.cmd.op) &&
                    !(eff_w >= `NBC_RAM_LO && eff_w <= `NBC_RAM_HI);
        s_d.phase = PH_READ;
      end
      PH_READ: begin
        s_d.phase = PH_LATCH;
      end
      PH_LATCH: begin
        s_d.mdata = s_q.internal ? ram_q[ram_idx] : dm_rdata_in;
        s_d.phase = PH_EXEC;
      end
      PH_EXEC: begin
        s_d.acc = alu_r.acc; // [RQ8]
        s_d.cy = alu_r.cy; // [RQ5]
        s_d.pc = pc_inc;
        if (alu_r.wr_mem && !s_q.internal) begin
          s_d.dm.we = 1'b1;
          s_d.dm.wdata = alu_r.mem;
        end
        case (s_q.cmd.op)
          OP_JUMP: s_d.pc = s_q.cmd.addr; // page bit loaded [RQ2] [RQ3]
          OP_CALL: s_d.pc = s_q.cmd.addr;
          OP_RET_INT: begin
            s_d.pc = top_w.pc; // [RQ15]
            s_d.cy = top_w.cy; // [RQ6]
          end
          OP_RET_CONST: begin
            s_d.pc = top_w.pc; // carry left alone [RQ7]
            s_d.table_branch_register = s_q.cmd.addr[7:4]; // [RQ10]
            s_d.acc = s_q.cmd.addr[3:0];
          end
          OP_TABLE_JUMP: s_d.pc = {s_q.pc[11:8], s_q.table_branch_register, s_q.acc}; // [RQ9]
          OP_BIT_BR: begin
            if (s_q.acc[s_q.cmd.imm[1:0]]) begin
              s_d.pc = {s_q.pc[11], s_q.cmd.addr[10:0]}; // [RQ4]
            end
          end
          OP_ZERO_BR: begin
            if (s_q.acc == 4'h0) begin
              s_d.pc = {s_q.pc[11], s_q.cmd.addr[10:0]};
            end
          end
          OP_CARRY_BR: begin
            if (s_q.cy) begin
              s_d.pc = {s_q.pc[11], s_q.cmd.addr[10:0]};
            end
          end
          default: s_d.pc = pc_inc;
        endcase
        s_d.phase = PH_IDLE;
      end
      default: s_d.phase = PH_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------

  // core state, pc starts at zero [RQ19]
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      s_q <= '0;
      s_q.phase <= PH_IDLE;
      s_q.pc <= `NBC_RESET_PC;
    end else begin
      s_q <= s_d;
    end
  end

  // data ram write during the execute phase [RQ20]
  always_ff @(posedge sys_clk_in) begin
    if (s_q.phase == PH_EXEC && alu_r.wr_mem && s_q.internal) begin
      ram_q[ram_idx] <= alu_r.mem;
    end
  end

  // outputs
  assign wb_ack_out = s_q.ack;
  assign wb_dat_out = s_q.rdata;
  assign rom_addr_out = s_q.pc; // twelve bits, 4K at most [RQ3]
  assign dm_out = s_q.dm;

endmodule

// [tb/nbc_core_sva.sv]
// concurrent checks on the nibble core's ports
module nbc_core_sva import nbc_pkg::*; (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // wishbone slave side
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  // fetch address and data port
  input wire logic [11:0] rom_addr_out,
  input wire nbc_dm_s dm_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  // a command write lands at this edge
  sequence s_cmd_land;
    wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_adr_in == `NBC_REG_CMD;
  endsequence
  // load from an address outside the core
  sequence s_ext_load;
    s_cmd_land ##0 (wb_dat_in[20:16] == OP_LOAD && wb_dat_in[9:0] != `NBC_INX_ADDR
      && !(wb_dat_in[9:0] inside {[`NBC_RAM_LO:`NBC_RAM_HI]}));
  endsequence

  a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  a_ack_next_cycle: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("request not answered in the next cycle");
  a_unmapped_zero: assert property (wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out
      && !(wb_adr_in inside {`NBC_REG_CMD, `NBC_REG_STATUS, `NBC_REG_DPTR, `NBC_REG_IRQ,
      `NBC_REG_CORE}) |=> wb_dat_out == 32'h0)
    else $error("unmapped read returned data");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst_in |=> !wb_ack_out
      && !dm_out.rd && !dm_out.we && rom_addr_out == `NBC_RESET_PC)
    else $error("outputs not cleared by reset");
  a_ram_stays_in: assert property ((dm_out.rd || dm_out.we)
      |-> !(dm_out.addr inside {[`NBC_RAM_LO:`NBC_RAM_HI]}))
    else $error("internal ram access shown outside");
  a_load_addr: assert property (s_ext_load
      |-> ##2 (dm_out.rd && dm_out.addr == $past(wb_dat_in[9:0], 2)))
    else $error("external load read missing or misplaced");
  a_read_cause: assert property (dm_out.rd
      |-> $past(wb_ack_out && wb_we_in && wb_adr_in == `NBC_REG_CMD, 2))
    else $error("data read without a command two cycles earlier");
  a_write_cause: assert property (dm_out.we
      |-> $past(wb_ack_out && wb_we_in && wb_adr_in == `NBC_REG_CMD, 5))
    else $error("data write without a command five cycles earlier");
  a_pc_hold: assert property (s_cmd_land |=> $stable(rom_addr_out)[*4])
    else $error("pc moved before the instruction finished");
endmodule

bind nbc_core nbc_core_sva u_sva (.sys_clk_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
  .wb_adr_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .rom_addr_out, .dm_out);

// [tb/nbc_mem_model.sv]
// behavioural data memory and system registers beyond the core
module nbc_mem_model import nbc_pkg::*; (
  // clock
  input wire logic sys_clk_in,
  // access from the core
  input wire nbc_dm_s dm_in,
  output logic [3:0] rdata_out
);
  logic [3:0] mem [0:1023];
  // known fill pattern
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 4'(i) ^ 4'(i >> 4);
    end
    rdata_out = 4'h0;
  end
  // read answer stands one cycle, then the line toggles
  always @(posedge sys_clk_in) begin
    if (dm_in.rd) begin
      rdata_out <= mem[dm_in.addr];
    end else begin
      rdata_out <= ~rdata_out;
    end
    if (dm_in.we) begin
      mem[dm_in.addr] <= dm_in.wdata;
    end
  end
endmodule

// [tb/nbc_core_tb_top.sv]
// self-checking bench for the nibble core datapath
module nbc_core_tb_top import nbc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'hF;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd_d;
  logic wb_ack_out;
  logic adc_irq_in = 1'b0, tmr0_irq_in = 1'b0, tmr1_irq_in = 1'b0;
  logic [1:0] port_grp_in = 2'h3;
  logic [11:0] rom_addr_out;
  nbc_dm_s dm_out;
  logic [3:0] dm_rdata_in, a, m, i;
  logic c;
  logic [4:0] ex;
  logic [63:0] notes [$];
  logic [63:0] nt;
  int miscompares = 0, checks = 0, cycles = 0;
  integer seed = 32'h74495407;
  nbc_op_e ops [12] = '{OP_ADD, OP_ADC, OP_ADI, OP_SBI, OP_AND, OP_EOR, OP_OR, OP_DEC_ADD,
    OP_DEC_SUB, OP_SBC, OP_SUB, OP_SHIFT_R};

  always #5 sys_clk_in = ~sys_clk_in;

  nbc_core dut (.sys_clk_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .adc_irq_in, .tmr0_irq_in,
    .tmr1_irq_in, .port_grp_in, .rom_addr_out, .dm_out, .dm_rdata_in);
  nbc_mem_model u_mem (.sys_clk_in, .dm_in(dm_out), .rdata_out(dm_rdata_in));

  // ----------------------------------------
  // reporting and bus tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: memory got %h want %h", $time, got, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb_go(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= ad;
    wb_dat_in <= d;
    do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
    rd_d = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask

  // read with a note of the expected masked value
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp, input logic [31:0] msk);
    notes.push_back({exp & msk, msk});
    wb_go(1'b0, ad, 32'h0);
  endtask

  // issue one instruction and wait for busy to clear
  task automatic run(input nbc_op_e op, input logic [11:0] ad);
    wb_go(1'b1, `NBC_REG_CMD, {11'h0, op, i, ad});
    do rd(`NBC_REG_CMD, 32'h0, 32'h0); while (rd_d[31] !== 1'b0);
  endtask

  // expected {cy, acc} of an alu step
  function automatic logic [4:0] alu_ref(nbc_op_e op);
    case (op)
      OP_ADD: return 5'(a) + 5'(m);
      OP_ADC: return 5'(a) + 5'(m) + 5'(c);
      OP_ADI: return 5'(m) + 5'(i);
      OP_SBI: return 5'(m) + {1'b0, ~i} + 5'h01;
      OP_SBC: return 5'(m) + {1'b0, ~a} + 5'(c);
      OP_SUB: return 5'(m) + {1'b0, ~a} + 5'h01;
      OP_SHIFT_R: return {a[0], 1'b0, a[3:1]};
      OP_AND: return {c, a & m};
      OP_EOR: return {c, a ^ m};
      OP_OR: return {c, a | m};
      OP_DEC_ADD: return (a > `NBC_BCD_MAX || c) ? {1'b1, a + 4'h6} : {c, a};
      default: return c ? {c, a} : {c, a - 4'h6};
    endcase
  endfunction

  // pair each read answer with the oldest note
  always @(posedge sys_clk_in) begin
    if (wb_ack_out === 1'b1 && wb_we_in === 1'b0 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt[31:0] != 32'h0) begin
        checks++;
        if ((wb_dat_out & nt[31:0]) !== nt[63:32]) begin
          miscompares++;
          $display("wrong value at %0t: read %h want %h", $time, wb_dat_out, nt[63:32]);
        end
      end
    end
  end

  // hang guard
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i = 4'h0;
    repeat (12) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    rd(`NBC_REG_STATUS, 32'h0, 32'h03FF_FFFF);
    rd(8'h2C, 32'h0, 32'hFFFF_FFFF);
    // masked source waits, enabled port edge is taken
    wb_go(1'b1, `NBC_REG_IRQ, 32'h1);
    @(posedge sys_clk_in) adc_irq_in <= 1'b1;
    @(posedge sys_clk_in) adc_irq_in <= 1'b0;
    rd(`NBC_REG_IRQ, 32'h81, 32'hFF);
    @(posedge sys_clk_in) port_grp_in <= 2'h2;
    repeat (4) @(posedge sys_clk_in);
    rd(`NBC_REG_STATUS, 32'h0020_0004, 32'h01E0_0FFF);
    rd(`NBC_REG_IRQ, 32'h81, 32'hFF);
    run(OP_RET_INT, 12'h0);
    rd(`NBC_REG_STATUS, 32'h0, 32'h01E0_0FFF);
    wb_go(1'b1, `NBC_REG_IRQ, 32'h8);
    repeat (4) @(posedge sys_clk_in);
    rd(`NBC_REG_STATUS, 32'h0020_0001, 32'h01E0_0FFF);
    rd(`NBC_REG_IRQ, 32'h08, 32'hFF);
    // both timers at once: timer0 first, then timer1
    wb_go(1'b1, `NBC_REG_IRQ, 32'h6);
    @(posedge sys_clk_in) begin
      tmr0_irq_in <= 1'b1;
      tmr1_irq_in <= 1'b1;
    end
    @(posedge sys_clk_in) begin
      tmr0_irq_in <= 1'b0;
      tmr1_irq_in <= 1'b0;
    end
    repeat (2) @(posedge sys_clk_in);
    rd(`NBC_REG_STATUS, 32'h0060_0003, 32'h01E0_0FFF);
    rd(`NBC_REG_IRQ, 32'h06, 32'hFF);
    // second reset in mid-run
    @(posedge sys_clk_in) nrst_in <= 1'b0;
    port_grp_in <= 2'h3;
    repeat (3) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    rd(`NBC_REG_STATUS, 32'h0, 32'h03FF_FFFF);
    // random alu steps on internal ram
    for (int k = 0; k < 24; k++) begin
      {c, i, m, a} = 13'($random(seed));
      wb_go(1'b1, `NBC_REG_CORE, {28'h0, m});
      run(OP_STORE, 12'h040);
      wb_go(1'b1, `NBC_REG_CORE, {23'h0, c, 4'h0, a});
      run(ops[k % 12], 12'h040);
      ex = alu_ref(ops[k % 12]);
      rd(`NBC_REG_STATUS, {11'h0, ex[4], 4'h0, ex[3:0], 12'h0}, 32'h001F_F000);
    end
    // external and pointer transfers
    i = 4'h0;
    wb_go(1'b1, `NBC_REG_CORE, 32'h7);
    run(OP_STORE, 12'h200);
    expect_eq(32'(u_mem.mem[10'h200]), 32'h7);
    wb_go(1'b1, `NBC_REG_DPTR, 32'h3FF);
    rd(`NBC_REG_DPTR, 32'h3FF, 32'h3FF);
    wb_go(1'b1, `NBC_REG_CORE, 32'h9);
    run(OP_STORE, `NBC_INX_ADDR);
    expect_eq(32'(u_mem.mem[10'h3FF]), 32'h9);
    wb_go(1'b1, `NBC_REG_DPTR, 32'h2B6);
    run(OP_LOAD, `NBC_INX_ADDR);
    rd(`NBC_REG_STATUS, {16'h0, u_mem.mem[10'h2B6], 12'h0}, 32'hF000);
    run(OP_LOAD, 12'h1C3);
    rd(`NBC_REG_STATUS, {16'h0, u_mem.mem[10'h1C3], 12'h0}, 32'hF000);
    // page jump, nine nested calls, returns, table jump
    run(OP_JUMP, 12'h800);
    rd(`NBC_REG_STATUS, 32'h800, 32'hFFF);
    wb_go(1'b1, `NBC_REG_CORE, 32'h100);
    for (int n = 0; n < 9; n++) begin
      run(OP_CALL, 12'(12'h810 + 2 * n));
    end
    rd(`NBC_REG_STATUS, 32'h0310_0820, 32'h03F0_0FFF);
    wb_go(1'b1, `NBC_REG_CORE, 32'h0);
    run(OP_RET_INT, 12'h0);
    rd(`NBC_REG_STATUS, 32'h02F0_081F, 32'h03F0_0FFF);
    wb_go(1'b1, `NBC_REG_CORE, 32'h0);
    run(OP_RET_CONST, 12'h0A5);
    rd(`NBC_REG_STATUS, 32'h02CA_581D, 32'h03FF_FFFF);
    run(OP_TABLE_JUMP, 12'h0);
    rd(`NBC_REG_STATUS, 32'h8A5, 32'hFFF);
    // bit 0 of acc is set, carry is clear: taken, then not taken
    run(OP_BIT_BR, 12'h123);
    rd(`NBC_REG_STATUS, 32'h923, 32'hFFF);
    run(OP_CARRY_BR, 12'h456);
    rd(`NBC_REG_STATUS, 32'h924, 32'hFFF);
    for (int j = 0; j < 6; j++) begin
      run(OP_RET_INT, 12'h0);
      rd(`NBC_REG_STATUS, {7'h0, 4'(5 - j), 9'h0, 12'(12'h80F + 2 * (6 - j))}, 32'h01E0_0FFF);
    end
    tally_and_finish();
  end
endmodule
